// File: rtl/brk_core.sv
// Breaker threshold register bank, trip logic and current result storage.
//
// Two channels share one register port. Each channel keeps a threshold code, a
// ratio field and a range field. The fast and slow thresholds are worked out again
// on every clock, so software may change any of them while power flows.
// Converter results are kept per channel and read back as an upper byte plus a
// two-bit remainder at the next address. Trips are latched until the channel is
// restarted; a latched trip pulls the gate low and holds the fault pin low.
// The analog comparators sit outside. This block only compares converter counts,
// so its slow trip is an integral over samples rather than a true time delay.
//
// Function
// R1: Ratio field selects 125, 150, 175, 200 percent.
// R2: Ratio resets to the 200 percent setting.
// R3: Slow threshold is fast threshold over ratio.
// R4: Code spans 40 to 100 percent full scale.
// R5: Range codes select 25, 50, 100 mV.
// R6: Range field loads from strap pin at power-up.
// R7: Range register: channel one bits 1:0, two 3:2.
// R8: One code sets both thresholds; resets 0xBF.
// R9: Software computes code from slow voltage, ratio.
// R10: New settings apply while the channel runs.
// R11: Fast above slow; fast crossing shuts down quickly.
// R12: Slow trip delay shrinks with larger overdrive.
// R13: Shutdown asserts the channel's open-drain fault output.
// R14: Latest 10-bit result per channel is readable.
// R15: Upper eight bits low address, two bits next.
// R16: Same byte split for every 10-bit value.
// R17: Ratio register: bits 1:0, 3:2; resets 0x0F.
// R18: Either threshold crossing pulls the gate low.
// R19: Range bits 7:4 read zero; code 11 is 25 mV.
`default_nettype none
module brk_core #(
    parameter logic [15:0] SLOW_LIMIT = brk_pkg::SLOW_LIMIT_DEF
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire brk_pkg::brk_req_t reg_req,
    output logic [7:0] reg_rdata,
    input wire brk_pkg::brk_sample_t adc_sample,
    input wire logic [3:0] range_strap_pin,
    input wire logic [1:0] chan_restart,
    output brk_pkg::brk_thr_t [1:0] chan_thr,
    output logic [1:0] gate_off,
    input wire logic [1:0] fault_i,
    output logic [1:0] fault_o,
    output logic [1:0] fault_oe,
    output logic [1:0] fault_seen
);
    import brk_pkg::*;

    // Every flip-flop of the block lives in this one record.
    // One record keeps the register step to a single line and the reset to six.
    typedef struct packed {
        logic [3:0] strap_s1; // First synchroniser stage, read only by the second.
        logic [3:0] strap_s2; // Second synchroniser stage.
        logic [1:0] fault_s1; // First stage for the fault wire readback.
        logic [1:0] fault_s2; // Second stage for the fault wire readback.
        brk_phase_t phase; // Waiting for the strap or running.
        logic [1:0] settle; // Cycles since reset release.
        logic [1:0][7:0] trip_code; // Threshold code per channel.
        logic [3:0] ratio; // Two ratio bits per channel.
        logic [3:0] range; // Two range bits per channel.
        logic [1:0][9:0] sample; // Latest current result per channel.
        logic [1:0][15:0] slow_acc; // Overdrive integral per channel.
        logic [1:0] shut; // Channel held off by a trip.
        logic [1:0][9:0] fast_thr; // Fast threshold in result counts.
        logic [1:0][9:0] slow_thr; // Slow threshold in result counts.
        logic [1:0][1:0] fs_code; // Normalised range code to the front end.
        logic [7:0] rdata; // Registered read answer.
    } brk_state_t;

    brk_state_t st; // Present state.
    brk_state_t next_st; // State for the coming edge.

    // Scale factor for a ratio code; the slow threshold is fast times this over 256.
    // The factors are rounded to the nearest 1/256, so the slow threshold may sit one
    // count away from the exact quotient, but it always stays below the fast one.
    function automatic logic [7:0] brk_scale(input logic [1:0] code);
        logic [7:0] k;
        k = SCALE_200;
        case (code)
            RATIO_125: k = SCALE_125; // R1
            RATIO_150: k = SCALE_150; // R1
            RATIO_175: k = SCALE_175; // R1
            default: k = SCALE_200; // R1
        endcase
        return k;
    endfunction

    // All next-state logic: synchronisers, register writes, thresholds and trips.
    always_comb begin
        logic [7:0] eff_code;
        logic [9:0] fast10;
        logic [17:0] prod;
        logic [9:0] od;
        logic [16:0] acc_sum;
        logic [1:0] rcode;
        logic hit;
        eff_code = 8'h00;
        fast10 = 10'h000;
        prod = 18'h00000;
        od = 10'h000;
        acc_sum = 17'h00000;
        rcode = 2'h0;
        hit = 1'b0;
        next_st = st;

        // Pins from outside the clock domain pass two flip-flops first.
        // The fault wire is read back only so software can see it; no logic acts on it.
        next_st.strap_s1 = range_strap_pin;
        next_st.strap_s2 = st.strap_s1;
        next_st.fault_s1 = fault_i;
        next_st.fault_s2 = st.fault_s1;

        // Power-up load of the range field once the synchroniser has filled.
        // Loading any earlier would latch the reset zeros of the synchroniser,
        // which decode as the 100 mV range whatever the pin says. The cost is a
        // few cycles after reset in which the front end sees the widest range.
        case (st.phase)
            BRK_STRAP_WAIT: begin
                if (st.settle == STRAP_SETTLE) begin
                    next_st.range = st.strap_s2; // R6
                    next_st.phase = BRK_RUN;
                end else begin
                    next_st.settle = 2'(st.settle + 2'h1);
                end
            end
            default: begin
                next_st.phase = BRK_RUN;
            end
        endcase

        // Register writes; a write after the load overrides the strap value.
        // Bits 7:4 of the two short registers are not stored, so they read as zero.
        if (reg_req.wr) begin
            if (reg_req.addr == ADDR_TRIP0) begin
                next_st.trip_code[0] = reg_req.wdata; // R8
            end else if (reg_req.addr == ADDR_TRIP1) begin
                next_st.trip_code[1] = reg_req.wdata; // R8
            end else if (reg_req.addr == ADDR_RATIO) begin
                next_st.ratio = reg_req.wdata[3:0]; // R17
            end else if (reg_req.addr == ADDR_RANGE) begin
                next_st.range = reg_req.wdata[3:0]; // R7 R19
            end
        end

        // Read answer, registered; only the low nibble of a short register is kept.
        // The answer is zero in every cycle without a read, so a stale byte can never
        // be mistaken for a fresh answer by the serial engine.
        next_st.rdata = UNMAPPED_DATA;
        if (reg_req.rd) begin
            if (reg_req.addr == ADDR_CS_MSB0) begin
                next_st.rdata = st.sample[0][9:2]; // R15 R16
            end else if (reg_req.addr == ADDR_CS_LSB0) begin
                next_st.rdata = {6'h00, st.sample[0][1:0]}; // R15 R16
            end else if (reg_req.addr == ADDR_CS_MSB1) begin
                next_st.rdata = st.sample[1][9:2]; // R15 R16
            end else if (reg_req.addr == ADDR_CS_LSB1) begin
                next_st.rdata = {6'h00, st.sample[1][1:0]}; // R15 R16
            end else if (reg_req.addr == ADDR_TRIP0) begin
                next_st.rdata = st.trip_code[0];
            end else if (reg_req.addr == ADDR_TRIP1) begin
                next_st.rdata = st.trip_code[1];
            end else if (reg_req.addr == ADDR_RATIO) begin
                next_st.rdata = {4'h0, st.ratio};
            end else if (reg_req.addr == ADDR_RANGE) begin
                next_st.rdata = {4'h0, st.range}; // R19
            end
        end

        // Per-channel thresholds and trip decisions.
        for (int ch = 0; ch < 2; ch++) begin
            // Codes below 40 percent are lifted so the fast threshold never sinks lower.
            // The register still reads back the code as written; only the threshold
            // handed to the front end is lifted.
            eff_code = (st.trip_code[ch] < CODE_MIN) ? CODE_MIN : st.trip_code[ch]; // R4
            fast10 = {eff_code, 2'h0}; // R4
            // Recomputed every cycle, so a new code, ratio or range takes effect live.
            prod = 18'(fast10) * 18'(brk_scale(st.ratio[ch * FIELD_W +: FIELD_W])); // R3 R10
            next_st.fast_thr[ch] = fast10;
            next_st.slow_thr[ch] = prod[17:8]; // R3 R11
            rcode = st.range[ch * FIELD_W +: FIELD_W];
            next_st.fs_code[ch] = (rcode == RNG_SPARE) ? RNG_25MV : rcode; // R5 R19

            hit = 1'b0;
            if (adc_sample.valid && (adc_sample.chan == ch[0])) begin
                next_st.sample[ch] = adc_sample.data; // R14
                // The fast comparison uses the incoming sample, not the stored copy.
                if (adc_sample.data > st.fast_thr[ch]) begin
                    hit = 1'b1; // R11 R18
                end
                if (adc_sample.data > st.slow_thr[ch]) begin
                    // Bigger overdrive fills the integral faster, so the delay shrinks.
                    // Limitation: the integral only moves when a sample of this channel
                    // arrives, so the delay also scales with the converter rate.
                    od = adc_sample.data - st.slow_thr[ch]; // R12
                    acc_sum = {1'b0, st.slow_acc[ch]} + {7'h00, od};
                    if (acc_sum >= {1'b0, SLOW_LIMIT}) begin
                        hit = 1'b1; // R12 R18
                        next_st.slow_acc[ch] = SLOW_LIMIT;
                    end else begin
                        next_st.slow_acc[ch] = acc_sum[15:0];
                    end
                end else if (st.slow_acc[ch] != 16'h0000) begin
                    // Short, small excursions leak away instead of tripping.
                    next_st.slow_acc[ch] = st.slow_acc[ch] - 16'h0001; // R12
                end
            end

            // A trip in the same cycle as a restart wins over the restart.
            if (hit) begin
                next_st.shut[ch] = 1'b1; // R18
            end else if (chan_restart[ch]) begin
                next_st.shut[ch] = 1'b0;
                next_st.slow_acc[ch] = 16'h0000;
            end
        end
    end

    // Synchronous reset puts constants only into the state record.
    // The range field resets to the 100 mV code and is replaced by the strap
    // value once the synchroniser has settled.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            st <= '0;
            st.phase <= BRK_STRAP_WAIT;
            st.trip_code <= {TRIP_RST, TRIP_RST}; // R8
            st.ratio <= RATIO_RST; // R2 R17
            st.range <= {RNG_100MV, RNG_100MV};
            st.rdata <= UNMAPPED_DATA;
        end else begin
            st <= next_st;
        end
    end

    // Outputs other than the constant fault level are taken straight from the state record.
    // The fault pin is open-drain: its level is always low and only the enable
    // moves, so an outside pull-up supplies the released level.
    always_comb begin
        reg_rdata = st.rdata;
        gate_off = st.shut;
        fault_o = 2'h0; // The fault pin only ever pulls low.
        fault_oe = st.shut; // R13
        fault_seen = st.fault_s2;
        for (int ch = 0; ch < 2; ch++) begin
            chan_thr[ch].fast = st.fast_thr[ch];
            chan_thr[ch].slow = st.slow_thr[ch];
            chan_thr[ch].fs_code = st.fs_code[ch];
        end
    end

    // The threshold code resets to its documented value.
    trip_reset_a: assert property (@(posedge core_clk) // R8
        $rose(rstn) |-> st.trip_code[0] == TRIP_RST && st.ratio == RATIO_RST)
        else $error("threshold code or ratio wrong after reset");

    // A ratio write lands in the next cycle.
    ratio_write_a: assert property (@(posedge core_clk) disable iff (!rstn) // R17
        reg_req.wr && reg_req.addr == ADDR_RATIO |=> st.ratio == $past(reg_req.wdata[3:0]))
        else $error("ratio write not stored");

    // Upper range bits always read as zero.
    range_read_a: assert property (@(posedge core_clk) disable iff (!rstn) // R19
        reg_req.rd && reg_req.addr == ADDR_RANGE |=> reg_rdata[7:4] == 4'h0
        && reg_rdata[3:0] == $past(st.range))
        else $error("range register read wrong");

    // The 200 percent ratio halves the fast threshold.
    half_ratio_a: assert property (@(posedge core_clk) disable iff (!rstn) // R1
        st.ratio[1:0] == RATIO_200 && st.phase == BRK_RUN
        |=> st.slow_thr[0] == {1'b0, st.fast_thr[0][9:1]})
        else $error("slow threshold not half of fast at 200 percent");

    // The slow threshold stays below the fast one.
    fast_above_a: assert property (@(posedge core_clk) disable iff (!rstn) // R11
        st.phase == BRK_RUN |-> st.slow_thr[1] < st.fast_thr[1])
        else $error("slow threshold not below fast threshold");

    // A new code reaches the fast threshold two cycles after the write.
    code_track_a: assert property (@(posedge core_clk) disable iff (!rstn) // R3
        reg_req.wr && reg_req.addr == ADDR_TRIP0 && reg_req.wdata >= CODE_MIN
        ##1 !(reg_req.wr && reg_req.addr == ADDR_TRIP0)
        |=> st.fast_thr[0] == {$past(reg_req.wdata, 2), 2'h0})
        else $error("fast threshold did not follow the code");

    // A sample above the fast threshold shuts the channel and pulls fault.
    fast_trip_a: assert property (@(posedge core_clk) disable iff (!rstn) // R13
        adc_sample.valid && !adc_sample.chan && adc_sample.data > st.fast_thr[0]
        |=> gate_off[0] && fault_oe[0] && !fault_o[0])
        else $error("fast crossing did not shut the channel");

    // The strap value is loaded when the wait ends.
    strap_load_a: assert property (@(posedge core_clk) disable iff (!rstn) // R6
        st.phase == BRK_STRAP_WAIT && st.settle == STRAP_SETTLE
        && !(reg_req.wr && reg_req.addr == ADDR_RANGE)
        |=> st.range == $past(st.strap_s2) && st.phase == BRK_RUN)
        else $error("range field not loaded from the strap");

    // The upper eight bits of a stored sample read back at the upper result address.
    sample_split_a: assert property (@(posedge core_clk) disable iff (!rstn) // R15
        adc_sample.valid && adc_sample.chan ##1 !adc_sample.valid ##1 !adc_sample.valid
        && reg_req.rd && reg_req.addr == ADDR_CS_MSB1
        |=> reg_rdata == $past(adc_sample.data[9:2], 3))
        else $error("upper result byte wrong");

    // Spare range code is treated as the smallest range.
    spare_code_a: assert property (@(posedge core_clk) disable iff (!rstn) // R5
        st.range[1:0] == RNG_SPARE |=> st.fs_code[0] == RNG_25MV)
        else $error("spare range code not mapped to 25 mV");

    // A range write lands in the next cycle and wins over the strap load.
    range_write_a: assert property (@(posedge core_clk) disable iff (!rstn) // R7
        reg_req.wr && reg_req.addr == ADDR_RANGE |=> st.range == $past(reg_req.wdata[3:0]))
        else $error("range write not stored");

    // The front end sees each stored range code, spare code aside.
    range_decode_a: assert property (@(posedge core_clk) disable iff (!rstn) // R5
        st.range[3:2] != RNG_SPARE |=> st.fs_code[1] == $past(st.range[3:2]))
        else $error("range code not passed to the front end");

    // A restart with no trip in the same cycle reopens the channel.
    restart_clear_a: assert property (@(posedge core_clk) disable iff (!rstn) // R18
        chan_restart[0] && !(adc_sample.valid && !adc_sample.chan) |=> !gate_off[0])
        else $error("restart did not reopen the channel");

    // A latched trip stands until a restart arrives.
    trip_hold_a: assert property (@(posedge core_clk) disable iff (!rstn) // R18
        gate_off[1] && !chan_restart[1] |=> gate_off[1] && fault_oe[1])
        else $error("trip released without a restart");

    // A sample at or below the slow threshold never starts a trip.
    small_skip_a: assert property (@(posedge core_clk) disable iff (!rstn) // R12
        adc_sample.valid && adc_sample.chan && adc_sample.data <= st.slow_thr[1]
        && !gate_off[1] |=> !gate_off[1])
        else $error("sample below the slow threshold tripped the channel");

    // The low result byte holds only the two remainder bits.
    sample_low_a: assert property (@(posedge core_clk) disable iff (!rstn) // R16
        reg_req.rd && reg_req.addr == ADDR_CS_LSB1 |=> reg_rdata[7:2] == 6'h00
        && reg_rdata[1:0] == $past(st.sample[1][1:0]))
        else $error("lower result byte wrong");

endmodule
`default_nettype wire

// File: rtl/brk_pkg.sv
// Constants and carrier types for the breaker threshold configuration block.
`default_nettype none
package brk_pkg;

    // Byte addresses of the registers that this block answers.
    localparam logic [7:0] ADDR_CS_MSB0 = 8'h00; // First channel current result, bits 9:2.
    localparam logic [7:0] ADDR_CS_LSB0 = 8'h01; // First channel current result, bits 1:0.
    localparam logic [7:0] ADDR_CS_MSB1 = 8'h04; // Second channel current result, bits 9:2.
    localparam logic [7:0] ADDR_CS_LSB1 = 8'h05; // Second channel current result, bits 1:0.
    localparam logic [7:0] ADDR_TRIP0 = 8'h2E; // trip_code_first_channel.
    localparam logic [7:0] ADDR_TRIP1 = 8'h2F; // trip_code_second_channel.
    localparam logic [7:0] ADDR_RATIO = 8'h30; // trip_ratio_register.
    localparam logic [7:0] ADDR_RANGE = 8'h33; // sense_range_select.

    // Reset values.
    localparam logic [7:0] TRIP_RST = 8'hBF; // Threshold code after reset.
    localparam logic [3:0] RATIO_RST = 4'hF; // Both channels at the 200 percent ratio.
    localparam logic [7:0] UNMAPPED_DATA = 8'h00; // Read answer for an unused address.

    // Field layout of the two-channel registers: channel n sits at bits 2n+1:2n.
    localparam int FIELD_W = 2;

    // Fast-to-slow ratio codes.
    localparam logic [1:0] RATIO_125 = 2'h0;
    localparam logic [1:0] RATIO_150 = 2'h1;
    localparam logic [1:0] RATIO_175 = 2'h2;
    localparam logic [1:0] RATIO_200 = 2'h3;

    // Slow threshold scale, in 1/256 steps: 100 divided by the ratio in percent.
    localparam logic [7:0] SCALE_125 = 8'hCD;
    localparam logic [7:0] SCALE_150 = 8'hAB;
    localparam logic [7:0] SCALE_175 = 8'h92;
    localparam logic [7:0] SCALE_200 = 8'h80;

    // Sense range codes; the strap pin sensor delivers the same encoding.
    localparam logic [1:0] RNG_100MV = 2'h0; // Pin open.
    localparam logic [1:0] RNG_50MV = 2'h1; // Pin high.
    localparam logic [1:0] RNG_25MV = 2'h2; // Pin low.
    localparam logic [1:0] RNG_SPARE = 2'h3; // Unused code.

    // Lowest effective threshold code: 40 percent of 255.
    localparam logic [7:0] CODE_MIN = 8'h66;

    // Cycles the strap synchroniser needs before its output is trusted.
    localparam logic [1:0] STRAP_SETTLE = 2'h2;

    // Default overdrive integral, in result counts, that ends a slow trip.
    localparam logic [15:0] SLOW_LIMIT_DEF = 16'h0400;

    // Phase of the power-up load of the range field.
    typedef enum logic [0:0] {
        BRK_STRAP_WAIT = 1'b0,
        BRK_RUN = 1'b1
    } brk_phase_t;

    // One converted current sample from the converter.
    typedef struct packed {
        logic valid;
        logic chan;
        logic [9:0] data;
    } brk_sample_t;

    // Thresholds and sense range handed to the front end of one channel.
    typedef struct packed {
        logic [9:0] fast;
        logic [9:0] slow;
        logic [1:0] fs_code;
    } brk_thr_t;

    // Register side request from the serial interface engine.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } brk_req_t;

endpackage
`default_nettype wire

// File: bench/brk_host_model.sv
// Register host model that issues byte reads and writes to the bank.
`default_nettype none
module brk_host_model (
    input wire logic core_clk,
    output brk_pkg::brk_req_t reg_req,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import brk_pkg::*;

    // The host is idle from time zero.
    initial reg_req = '0;

    // Writes one byte; the strobe stands for exactly one rising edge.
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge core_clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(negedge core_clk);
        // Released fields show the inverse, so a stale value cannot pass for live data.
        reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
    endtask

    // Reads one byte; the answer stands for the cycle after the strobe.
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(negedge core_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(negedge core_clk);
        data = reg_rdata;
        reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: 8'hFF};
    endtask
endmodule
`default_nettype wire

// File: bench/tb_brk_core.sv
// Self-checking bench for the breaker threshold register bank.
`default_nettype none
module tb_brk_core;
    timeunit 1ns;
    timeprecision 1ps;
    import brk_pkg::*;

    logic core_clk = 1'b0; // Runs at 20 MHz.
    logic rstn = 1'b0; // Held low for the first twelve cycles.
    brk_req_t reg_req; // Driven by the host model.
    logic [7:0] reg_rdata;
    brk_sample_t adc_sample = '0;
    logic [3:0] range_strap_pin = 4'h6; // Channel one pin high, channel zero pin low.
    logic [1:0] chan_restart = 2'h0;
    brk_thr_t [1:0] chan_thr;
    logic [1:0] gate_off;
    logic [1:0] fault_o;
    logic [1:0] fault_oe;
    logic [1:0] fault_seen;
    logic [1:0] fault_wire; // Pulled up; low while the bank drives it.
    logic [7:0] rd_val;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [9:0] slow_exp [4] = '{10'h19A, 10'h156, 10'h124, 10'h100};

    assign fault_wire = ~fault_oe;

    brk_core #(.SLOW_LIMIT(16'h0020)) i_dut (
        .core_clk(core_clk), .rstn(rstn), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .adc_sample(adc_sample), .range_strap_pin(range_strap_pin),
        .chan_restart(chan_restart), .chan_thr(chan_thr), .gate_off(gate_off),
        .fault_i(fault_wire), .fault_o(fault_o), .fault_oe(fault_oe), .fault_seen(fault_seen)
    );

    brk_host_model i_host (.core_clk(core_clk), .reg_req(reg_req), .reg_rdata(reg_rdata));

    // Free-running clock.
    initial forever #25 core_clk = ~core_clk;

    // Prints the verdict and ends the run.
    task automatic test_done();
        if (mismatches == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Compares a value of up to ten bits.
    task automatic chk_v(input logic [9:0] got, input logic [9:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Compares a two-bit per-channel flag or code.
    task automatic chk_f(input logic [1:0] got, input logic [1:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    // Reads a register and compares the byte.
    task automatic rdchk(input logic [7:0] addr, input logic [7:0] exp);
        i_host.rd(addr, rd_val);
        chk_v({2'h0, rd_val}, {2'h0, exp}, "register read");
    endtask

    // Lets a written setting reach the threshold outputs.
    task automatic settle();
        repeat (2) @(negedge core_clk);
    endtask

    // Presents one converter sample for a single cycle.
    task automatic smp(input logic ch, input logic [9:0] data);
        @(negedge core_clk);
        adc_sample <= '{valid: 1'b1, chan: ch, data: data};
        @(negedge core_clk);
        adc_sample <= '{valid: 1'b0, chan: ~ch, data: ~data};
    endtask

    // Pulses restart for both channels with no sample present.
    task automatic restart();
        chan_restart <= 2'h3;
        @(negedge core_clk);
        chan_restart <= 2'h0;
        @(negedge core_clk);
    endtask

    // Reset values and the strap load of the range field.
    task automatic t_reset();
        rdchk(ADDR_TRIP0, 8'hBF);
        rdchk(ADDR_TRIP1, 8'hBF);
        rdchk(ADDR_RATIO, 8'h0F);
        rdchk(ADDR_RANGE, 8'h06);
        chk_v(chan_thr[0].fast, 10'h2FC, "fast");
        chk_v(chan_thr[1].slow, 10'h17E, "slow");
        chk_f(chan_thr[0].fs_code, 2'h2, "range");
        chk_f(chan_thr[1].fs_code, 2'h1, "range");
    endtask

    // Every ratio code applied on the fly to a new threshold code.
    task automatic t_ratio();
        // Code that software derives from a slow voltage, ratio and range.
        i_host.wr(ADDR_TRIP0, 8'h80);
        for (int k = 0; k < 4; k++) begin
            i_host.wr(ADDR_RATIO, {6'h03, 2'(k)});
            settle();
            chk_v(chan_thr[0].fast, 10'h200, "fast");
            chk_v(chan_thr[0].slow, slow_exp[k], "slow");
        end
        i_host.wr(ADDR_RATIO, 8'hFF);
        rdchk(ADDR_RATIO, 8'h0F);
    endtask

    // Range rewrite, spare code, unused bits and the lowest code.
    task automatic t_range();
        i_host.wr(ADDR_RANGE, 8'hF3);
        rdchk(ADDR_RANGE, 8'h03);
        chk_f(chan_thr[0].fs_code, 2'h2, "range");
        chk_f(chan_thr[1].fs_code, 2'h0, "range");
        i_host.wr(ADDR_TRIP0, 8'h10);
        settle();
        chk_v(chan_thr[0].fast, 10'h198, "fast");
    endtask

    // Result storage split and an unmapped place.
    task automatic t_sample();
        smp(1'b1, 10'h0B6);
        rdchk(ADDR_CS_MSB1, 8'h2D);
        rdchk(ADDR_CS_LSB1, 8'h02);
        i_host.wr(8'h10, 8'h55);
        rdchk(8'h10, 8'h00);
    endtask

    // A sample over the fast threshold trips at once and drives the fault pin.
    task automatic t_fast();
        smp(1'b0, 10'h3FF);
        @(negedge core_clk);
        chk_f(gate_off, 2'b01, "gate");
        chk_f(fault_oe, 2'b01, "fault enable");
        chk_f(fault_o, 2'b00, "fault level");
        settle();
        chk_f(fault_seen, 2'b10, "fault wire");
        restart();
        chk_f(gate_off, 2'b00, "gate");
    endtask

    // Small overdrive needs four samples; a large one trips on the first.
    task automatic t_slow();
        for (int k = 0; k < 3; k++) begin
            smp(1'b1, 10'h186);
            @(negedge core_clk);
            chk_f(gate_off, 2'b00, "gate");
        end
        smp(1'b1, 10'h186);
        @(negedge core_clk);
        chk_f(gate_off, 2'b10, "gate");
        restart();
        smp(1'b1, 10'h1BE);
        @(negedge core_clk);
        chk_f(gate_off, 2'b10, "gate");
    endtask

    // Cuts a hang short.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            test_done();
        end
    end

    // Main sequence.
    initial begin
        repeat (12) @(negedge core_clk);
        rstn <= 1'b1;
        repeat (6) @(negedge core_clk);
        t_reset();
        t_ratio();
        t_range();
        t_sample();
        t_fast();
        t_slow();
        test_done();
    end
endmodule
`default_nettype wire
